// ---- src/adcs_pkg.sv ----
// constants and types shared by the conversion sequencer
package adcs_pkg;

   // ****************
   // register map
   // ****************
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] ACQ_CLK_OFS = 8'h04;
   localparam logic [7:0] RES_HI_OFS = 8'h08;
   localparam logic [7:0] RES_LO_OFS = 8'h0c;
   localparam logic [7:0] FLAGS_OFS = 8'h10;

   // control word bits
   localparam int ON_BIT = 0;
   localparam int GO_BIT = 1;
   // flag word bits
   localparam int DONE_BIT = 0;
   localparam int IRQ_EN_BIT = 1;
   // acquisition_clock_control fields
   localparam int JUSTIFY_BIT = 7;
   localparam int ACQ_LSB = 3;
   localparam int CLK_LSB = 0;
   localparam logic [7:0] ACQ_CLK_RESET = 8'h00;

   // ****************
   // timing
   // ****************
   localparam int CLK_PERIOD_NS = 10;
   localparam int INSTR_CYCLE_NS = 40;
   localparam int RC_DLY_CYC = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] RC_DLY_LAST = 3'(RC_DLY_CYC - 1);
   localparam logic [4:0] CONV_PERIODS = 5'h0b;
   localparam logic [4:0] WAIT_PERIODS = 5'h02;
   localparam int RESULT_W = 10;

   // ****************
   // types
   // ****************
   typedef enum logic [2:0] {
      ST_OFF,
      ST_SAMPLE,
      ST_RC_DELAY,
      ST_ACQUIRE,
      ST_CONVERT,
      ST_WAIT
   } adcs_phase_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } adcs_wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } adcs_wb_rsp_t;

   typedef struct packed {
      logic sample;
      logic convert;
      logic bit_tick;
   } adcs_core_ctl_t;

   typedef struct packed {
      adcs_phase_t phase;
      logic on;
      logic go;
      logic justify;
      logic [2:0] acq_sel;
      logic [2:0] clk_sel;
      logic done;
      logic irq_en;
      logic [5:0] div;
      logic [4:0] cnt;
      logic [2:0] dly;
      logic [2:0] rc_sync;
      logic rc_lvl;
      adcs_wb_rsp_t rsp;
      adcs_core_ctl_t core;
   } adcs_state_t;

endpackage

// ---- src/adcs_sequencer.sv ----
// conversion sequencer of a 10-bit successive-approximation converter
module adcs_sequencer (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   input wire logic rc_clk_pin,
   input wire logic device_sleep,
   input wire logic [9:0] core_result,
   output logic core_sample,
   output logic core_convert,
   output logic core_bit_tick
);

   // ****************
   // decoders
   // ****************
   // acquisition length decode
   function automatic logic [4:0] acq_periods(input logic [2:0] code);
      case (code)
         3'h7: acq_periods = 5'h14;
         3'h6: acq_periods = 5'h10;
         3'h5: acq_periods = 5'h0c;
         3'h4: acq_periods = 5'h08;
         3'h3: acq_periods = 5'h06;
         3'h2: acq_periods = 5'h04;
         3'h1: acq_periods = 5'h02;
         default: acq_periods = 5'h00;
      endcase
   endfunction

   // divider mask is ratio minus one
   function automatic logic [5:0] div_mask(input logic [2:0] code);
      case (code)
         3'h0: div_mask = 6'h01;
         3'h1: div_mask = 6'h07;
         3'h2: div_mask = 6'h1f;
         3'h4: div_mask = 6'h03;
         3'h5: div_mask = 6'h0f;
         3'h6: div_mask = 6'h3f;
         default: div_mask = 6'h00;
      endcase
   endfunction

   // x11 selects the internal RC clock
   function automatic logic is_rc(input logic [2:0] code);
      is_rc = (code[1:0] == 2'h3);
   endfunction

   // phases in which a started conversion is still under way
   function automatic logic in_flight(input adcs_pkg::adcs_phase_t ph);
      in_flight = (ph == adcs_pkg::ST_RC_DELAY) ||
                  (ph == adcs_pkg::ST_ACQUIRE) ||
                  (ph == adcs_pkg::ST_CONVERT);
   endfunction

   // the hold capacitor tracks the input until conversion begins
   function automatic logic tracks(input adcs_pkg::adcs_phase_t ph);
      tracks = (ph == adcs_pkg::ST_SAMPLE) ||
               (ph == adcs_pkg::ST_RC_DELAY) ||
               (ph == adcs_pkg::ST_ACQUIRE);
   endfunction

   adcs_pkg::adcs_state_t s_reg;
   adcs_pkg::adcs_state_t s_next;
   logic [7:0] res_hi_reg;
   logic [7:0] res_lo_reg;
   logic [7:0] res_hi_next;
   logic [7:0] res_lo_next;
   logic res_hi_load;
   logic res_lo_load;
   adcs_pkg::adcs_wb_req_t req;
   logic access;
   logic wr_lane;
   logic rc_rise;
   logic sys_tick;
   logic tick;
   logic go_write;
   logic go_value;
   logic start;
   logic finish;
   logic [4:0] acq_len;

   assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                  adr: wb_adr_i, dat: wb_dat_i};

   // ****************
   // next state
   // ****************
   always_comb begin
      s_next = s_reg;
      res_hi_next = res_hi_reg;
      res_lo_next = res_lo_reg;
      res_hi_load = 1'b0;
      res_lo_load = 1'b0;
      finish = 1'b0;
      start = 1'b0;

      // synchroniser for the rc clock; a change counts when stages 2 and 3 agree
      s_next.rc_sync = {s_reg.rc_sync[1:0], rc_clk_pin};
      if (s_reg.rc_sync[2] == s_reg.rc_sync[1]) begin
         s_next.rc_lvl = s_reg.rc_sync[2];
      end
      rc_rise = (s_reg.rc_sync[2] == s_reg.rc_sync[1]) && s_reg.rc_sync[2] && !s_reg.rc_lvl;

      // free-running divider of the system clock
      s_next.div = s_reg.div + 6'h01;
      // system-derived periods stop while the device sleeps
      sys_tick = ((s_reg.div & div_mask(s_reg.clk_sel)) == div_mask(s_reg.clk_sel))
                 && !device_sleep;
      // rc edges pace the bit period instead
      tick = is_rc(s_reg.clk_sel) ? rc_rise : sys_tick;
      acq_len = acq_periods(s_reg.acq_sel);

      // bus slave: ack one cycle after the request, dropped the next
      access = req.cyc && req.stb && !s_reg.rsp.ack;
      wr_lane = access && req.we && req.sel[0];
      s_next.rsp.ack = access;
      s_next.rsp.dat = 32'h0000_0000;
      go_write = wr_lane && (req.adr == adcs_pkg::CTRL_OFS);
      go_value = req.dat[adcs_pkg::GO_BIT];

      if (access && !req.we) begin
         case (req.adr)
            adcs_pkg::CTRL_OFS: begin
               s_next.rsp.dat[adcs_pkg::ON_BIT] = s_reg.on;
               s_next.rsp.dat[adcs_pkg::GO_BIT] = s_reg.go;
            end
            adcs_pkg::ACQ_CLK_OFS: begin
               // bit 6 is never stored and reads zero
               s_next.rsp.dat[adcs_pkg::JUSTIFY_BIT] = s_reg.justify;
               s_next.rsp.dat[adcs_pkg::ACQ_LSB +: 3] = s_reg.acq_sel;
               s_next.rsp.dat[adcs_pkg::CLK_LSB +: 3] = s_reg.clk_sel;
            end
            adcs_pkg::RES_HI_OFS: s_next.rsp.dat[7:0] = res_hi_reg;
            adcs_pkg::RES_LO_OFS: s_next.rsp.dat[7:0] = res_lo_reg;
            adcs_pkg::FLAGS_OFS: begin
               s_next.rsp.dat[adcs_pkg::DONE_BIT] = s_reg.done;
               s_next.rsp.dat[adcs_pkg::IRQ_EN_BIT] = s_reg.irq_en;
            end
            default: s_next.rsp.dat = 32'h0000_0000;
         endcase
      end

      if (wr_lane) begin
         case (req.adr)
            adcs_pkg::CTRL_OFS: s_next.on = req.dat[adcs_pkg::ON_BIT];
            adcs_pkg::ACQ_CLK_OFS: begin
               s_next.justify = req.dat[adcs_pkg::JUSTIFY_BIT];
               s_next.acq_sel = req.dat[adcs_pkg::ACQ_LSB +: 3];
               s_next.clk_sel = req.dat[adcs_pkg::CLK_LSB +: 3];
            end
            adcs_pkg::RES_HI_OFS: begin
               res_hi_next = req.dat[7:0];
               res_hi_load = 1'b1;
            end
            adcs_pkg::RES_LO_OFS: begin
               res_lo_next = req.dat[7:0];
               res_lo_load = 1'b1;
            end
            adcs_pkg::FLAGS_OFS: begin
               s_next.done = req.dat[adcs_pkg::DONE_BIT];
               s_next.irq_en = req.dat[adcs_pkg::IRQ_EN_BIT];
            end
            default: s_next.irq_en = s_reg.irq_en;
         endcase
      end

      // go may only be set while the converter is on and sampling, or already running;
      // a go taken while off or resting would never start and would stick high,
      // so a poller waiting for go to clear would hang forever
      if (go_write) begin
         s_next.go = go_value && req.dat[adcs_pkg::ON_BIT] &&
                     (s_reg.go || s_reg.phase == adcs_pkg::ST_SAMPLE);
         start = go_value && req.dat[adcs_pkg::ON_BIT] && !s_reg.go;
      end

      if (s_reg.cnt != 5'h00 && tick) begin
         s_next.cnt = s_reg.cnt - 5'h01;
      end

      case (s_reg.phase)
         adcs_pkg::ST_OFF: begin
            if (s_next.on) begin
               s_next.phase = adcs_pkg::ST_SAMPLE;
            end
         end
         adcs_pkg::ST_SAMPLE: begin
            if (start) begin
               s_next.dly = 3'h0;
               if (is_rc(s_reg.clk_sel)) begin
                  // hold off the rc clock one instruction cycle
                  s_next.phase = adcs_pkg::ST_RC_DELAY;
               end else if (acq_len == 5'h00) begin
                  s_next.phase = adcs_pkg::ST_CONVERT;
                  s_next.cnt = adcs_pkg::CONV_PERIODS;
               end else begin
                  s_next.phase = adcs_pkg::ST_ACQUIRE;
                  s_next.cnt = acq_len;
               end
            end
         end
         adcs_pkg::ST_RC_DELAY: begin
            s_next.dly = s_reg.dly + 3'h1;
            if (s_reg.dly == adcs_pkg::RC_DLY_LAST) begin
               s_next.phase = (acq_len == 5'h00) ? adcs_pkg::ST_CONVERT : adcs_pkg::ST_ACQUIRE;
               s_next.cnt = (acq_len == 5'h00) ? adcs_pkg::CONV_PERIODS : acq_len;
            end
         end
         adcs_pkg::ST_ACQUIRE: begin
            // go stays set, no separate phase flag
            if (s_reg.cnt == 5'h00 || (s_reg.cnt == 5'h01 && tick)) begin
               s_next.phase = adcs_pkg::ST_CONVERT;
               s_next.cnt = adcs_pkg::CONV_PERIODS;
            end
         end
         adcs_pkg::ST_CONVERT: begin
            if (s_reg.cnt == 5'h01 && tick) begin
               finish = 1'b1;
               s_next.phase = adcs_pkg::ST_WAIT;
               s_next.cnt = adcs_pkg::WAIT_PERIODS;
            end
         end
         adcs_pkg::ST_WAIT: begin
            // two bit periods before sampling again
            if (s_reg.cnt == 5'h00 || (s_reg.cnt == 5'h01 && tick)) begin
               s_next.phase = adcs_pkg::ST_SAMPLE;
            end
         end
         default: s_next.phase = adcs_pkg::ST_OFF;
      endcase

      // go cleared early aborts; results stay as they were
      if (go_write && !go_value && in_flight(s_reg.phase)) begin
         s_next.phase = adcs_pkg::ST_WAIT;
         s_next.cnt = adcs_pkg::WAIT_PERIODS;
         finish = 1'b0;
      end

      if (finish) begin
         // load result pair, clear go, set done (set beats clear)
         s_next.go = 1'b0;
         s_next.done = 1'b1;
         res_hi_load = 1'b1;
         res_lo_load = 1'b1;
         if (s_reg.justify) begin
            res_hi_next = {6'h00, core_result[9:8]};
            res_lo_next = core_result[7:0];
         end else begin
            res_hi_next = core_result[9:2];
            res_lo_next = {core_result[1:0], 6'h00};
         end
      end

      // switching off aborts anything in flight
      if (!s_next.on) begin
         s_next.phase = adcs_pkg::ST_OFF;
         s_next.go = 1'b0;
      end

      s_next.core.sample = tracks(s_next.phase);
      s_next.core.convert = (s_next.phase == adcs_pkg::ST_CONVERT);
      s_next.core.bit_tick = (s_reg.phase == adcs_pkg::ST_CONVERT) && tick;
   end

   // ****************
   // registers
   // ****************
   // reset returns every control field to its reset value
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '{phase: adcs_pkg::ST_OFF, on: 1'b0, go: 1'b0,
                    justify: adcs_pkg::ACQ_CLK_RESET[adcs_pkg::JUSTIFY_BIT],
                    acq_sel: adcs_pkg::ACQ_CLK_RESET[adcs_pkg::ACQ_LSB +: 3],
                    clk_sel: adcs_pkg::ACQ_CLK_RESET[adcs_pkg::CLK_LSB +: 3],
                    done: 1'b0, irq_en: 1'b0, div: 6'h00, cnt: 5'h00,
                    dly: 3'h0, rc_sync: 3'h0, rc_lvl: 1'b0,
                    rsp: '{ack: 1'b0, dat: 32'h0000_0000},
                    core: '{sample: 1'b0, convert: 1'b0, bit_tick: 1'b0}};
      end else begin
         s_reg <= s_next;
      end
   end

   // result bytes have no reset; contents undefined after power-up
   always_ff @(posedge sys_clk) begin
      if (res_hi_load) begin
         res_hi_reg <= res_hi_next;
      end
      if (res_lo_load) begin
         res_lo_reg <= res_lo_next;
      end
   end

   assign wb_ack_o = s_reg.rsp.ack;
   assign wb_dat_o = s_reg.rsp.dat;
   assign core_sample = s_reg.core.sample;
   assign core_convert = s_reg.core.convert;
   assign core_bit_tick = s_reg.core.bit_tick;

endmodule

// ---- verification/adcs_sequencer_sva.sv ----
// port assertions for the conversion sequencer
module adcs_sequencer_sva (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic core_sample,
   input wire logic core_convert,
   input wire logic core_bit_tick
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   logic req;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   sequence s_take(logic w, logic [7:0] a);
      req && wb_we_i == w && wb_adr_i == a;
   endsequence
   // sampling stays off for the first two clock cycles of the rest
   sequence s_rest;
      !core_sample [*2];
   endsequence
   a_ack_next: assert property (req |=> wb_ack_o) else $error("no ack");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
   a_wr_dat_zero: assert property (req && wb_we_i |=> wb_dat_o == 32'h0)
      else $error("data on write");
   a_spare_zero: assert property (s_take(1'b0, adcs_pkg::ACQ_CLK_OFS) |=> !wb_dat_o[6])
      else $error("bit 6 set");
   a_unmapped_zero: assert property (s_take(1'b0, 8'h14) |=> wb_dat_o == 32'h0)
      else $error("unmapped data");
   a_phase_excl: assert property (!(core_sample && core_convert))
      else $error("sample and convert");
   a_start_sample: assert property ($rose(core_convert) |-> $past(core_sample))
      else $error("start not from sampling");
   a_conv_min: assert property ($rose(core_convert) |-> core_convert [*8])
      else $error("short conversion");
   a_rest_wait: assert property ($fell(core_convert) |-> s_rest)
      else $error("no rest");
   a_tick_conv: assert property (core_bit_tick |-> core_convert || $past(core_convert))
      else $error("stray tick");
   a_reset_quiet: assert property ($rose(rst_b) |-> !core_convert && !core_sample && !wb_ack_o)
      else $error("busy after reset");
endmodule

bind adcs_sequencer adcs_sequencer_sva adcs_sequencer_sva_i (.sys_clk, .rst_b, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o, .wb_dat_o, .core_sample, .core_convert,
   .core_bit_tick);

// ---- verification/adcs_core_model.sv ----
// behavioural converter core and its rc oscillator
module adcs_core_model (
   input wire logic sys_clk,
   input wire logic [9:0] want,
   input wire logic core_convert,
   output logic [9:0] core_result,
   output logic rc_clk_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   initial rc_clk_pin = 1'b0;
   initial core_result = 10'h000;
   // free-running, period unrelated to sys_clk
   always #37 rc_clk_pin = !rc_clk_pin;
   // result only held while converting; churns otherwise
   always @(posedge sys_clk) core_result <= core_convert ? want : ~core_result;
endmodule

// ---- verification/adcs_sequencer_tb.sv ----
// self-checking bench for the conversion sequencer
module adcs_sequencer_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic wb_ack_o, rc_clk_pin, core_sample, core_convert, core_bit_tick;
   logic device_sleep = 1'b0;
   logic [31:0] wb_dat_o, rd, hi_keep;
   logic [9:0] core_result;
   logic [9:0] want = 10'h000;
   int mismatches = 0;
   int check_count = 0;
   int dv[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
   int ap[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
   int c;
   always #5 sys_clk = !sys_clk;
   adcs_sequencer adcs_sequencer_i (.sys_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i,
      .wb_adr_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .rc_clk_pin, .device_sleep, .core_result,
      .core_sample, .core_convert, .core_bit_tick);
   adcs_core_model adcs_core_model_i (.sys_clk, .want, .core_convert, .core_result, .rc_clk_pin);

   // ****************
   // shared tasks
   // ****************
   task automatic wrap_up;
      if (mismatches == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_up;
      mismatches++;
      $display("Error at %0t: timeout", $time);
      wrap_up();
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_sel_i <= 4'hf;
      wb_adr_i <= a;
      wb_dat_i <= d;
      i = 0;
      do begin
         @(posedge sys_clk);
         i++;
         if (i > 20) give_up();
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic wait_for(ref logic s, input logic v, output int n);
      n = 0;
      while (s !== v) begin
         @(posedge sys_clk);
         n++;
         if (n > 3000) give_up();
      end
   endtask

   // one conversion: start window, tick count, flags, result layout
   task automatic conv(input logic [2:0] acq, input logic [2:0] clk, input logic j,
                       input logic [9:0] r);
      int nd, lo, hi, len, ticks;
      nd = dv[clk];
      lo = nd == 0 ? 3 : (ap[acq] == 0 ? 0 : (ap[acq] - 1) * nd);
      hi = nd == 0 ? (ap[acq] + 1) * 8 + 10 : ap[acq] * nd + 3;
      bus(1'b1, adcs_pkg::ACQ_CLK_OFS, {24'h0, j, 1'b0, acq, clk});
      wait_for(core_sample, 1'b1, len);
      want <= r;
      // sleep only with the rc source
      device_sleep <= nd == 0;
      bus(1'b1, adcs_pkg::CTRL_OFS, 32'h3);
      wait_for(core_convert, 1'b1, len);
      check(32'(len >= lo && len <= hi), 32'h1);
      ticks = 0;
      len = 0;
      do begin
         @(posedge sys_clk);
         len++;
         if (core_bit_tick === 1'b1) ticks++;
         if (len > 1000) give_up();
      end while (core_convert === 1'b1);
      check(ticks, 11);
      if (nd > 0) check(32'(len >= 10 * nd && len <= 11 * nd + 2), 32'h1);
      device_sleep <= 1'b0;
      // poll go, read pair, clear done
      bus(1'b0, adcs_pkg::CTRL_OFS, 32'h0);
      check(rd, 32'h1);
      bus(1'b0, adcs_pkg::FLAGS_OFS, 32'h0);
      check(rd & 32'h1, 32'h1);
      bus(1'b0, adcs_pkg::RES_HI_OFS, 32'h0);
      check(rd, j ? 32'(r[9:8]) : 32'(r[9:2]));
      bus(1'b0, adcs_pkg::RES_LO_OFS, 32'h0);
      check(rd, j ? 32'(r[7:0]) : {24'h0, r[1:0], 6'h0});
      bus(1'b1, adcs_pkg::FLAGS_OFS, 32'h0);
   endtask

   // abort by clearing go, then a reset in mid-conversion
   task automatic abort_run;
      bus(1'b0, adcs_pkg::RES_HI_OFS, 32'h0);
      hi_keep = rd;
      want <= 10'h3c3;
      bus(1'b1, adcs_pkg::ACQ_CLK_OFS, 32'h86);
      wait_for(core_sample, 1'b1, c);
      bus(1'b1, adcs_pkg::CTRL_OFS, 32'h3);
      repeat (100) @(posedge sys_clk);
      bus(1'b0, adcs_pkg::CTRL_OFS, 32'h0);
      check(rd, 32'h3);
      bus(1'b1, adcs_pkg::CTRL_OFS, 32'h1);
      wait_for(core_convert, 1'b0, c);
      check(32'(c < 4), 32'h1);
      bus(1'b0, adcs_pkg::RES_HI_OFS, 32'h0);
      check(rd, hi_keep);
      wait_for(core_sample, 1'b1, c);
      bus(1'b1, adcs_pkg::CTRL_OFS, 32'h3);
      repeat (50) @(posedge sys_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check(core_convert, 1'b0);
      rst_b <= 1'b1;
      bus(1'b0, adcs_pkg::CTRL_OFS, 32'h0);
      check(rd, 32'h0);
      bus(1'b0, adcs_pkg::ACQ_CLK_OFS, 32'h0);
      check(rd, 32'(adcs_pkg::ACQ_CLK_RESET));
      bus(1'b0, adcs_pkg::RES_HI_OFS, 32'h0);
      check(rd, hi_keep);
   endtask

   initial begin
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      bus(1'b0, adcs_pkg::FLAGS_OFS, 32'h0);
      check(rd, 32'h0);
      bus(1'b1, adcs_pkg::ACQ_CLK_OFS, 32'hff);
      bus(1'b0, adcs_pkg::ACQ_CLK_OFS, 32'h0);
      check(rd, 32'hbf);
      bus(1'b1, 8'h14, 32'hff);
      bus(1'b0, 8'h14, 32'h0);
      check(rd, 32'h0);
      // go written together with power-up is refused, converter comes on idle
      bus(1'b1, adcs_pkg::CTRL_OFS, 32'h3);
      bus(1'b0, adcs_pkg::CTRL_OFS, 32'h0);
      check(rd, 32'h1);
      // every acquisition code on the fastest clock
      for (int k = 0; k < 8; k++) conv(3'(k), 3'h0, k[0], 10'h2a5 ^ 10'(k * 37));
      // clock codes 1 to 7, rc ones under sleep
      for (int k = 1; k < 8; k++) conv(3'h1, 3'(k), k[1], 10'h15a ^ 10'(k * 91));
      abort_run();
      wrap_up();
   end
endmodule
